// file: design/int_ack_map.vh
// constants for the interrupt acknowledge block: register offsets, fields, reset values, vectors
`ifndef INT_ACK_MAP_VH
`define INT_ACK_MAP_VH
// ****************************************
// wishbone register offsets (byte addresses)
// ****************************************
`define IA_OFF_PEND 8'h00
`define IA_OFF_MASK 8'h04
`define IA_OFF_PRIO 8'h08
`define IA_OFF_STAT 8'h0c
`define IA_OFF_VECT 8'h10
`define IA_OFF_VBASE 8'h14
// ****************************************
// field positions of the status word
// ****************************************
`define IA_BIT_ISP 1
`define IA_BIT_IE 7
// ****************************************
// reset values
// ****************************************
`define IA_RST_PEND 16'h0000
`define IA_RST_MASK 16'hffff
`define IA_RST_PRIO 16'hffff
`define IA_RST_PSW 8'h02
`define IA_RST_VBASE 16'h0004
// ****************************************
// trap vector pair and timing
// ****************************************
`define IA_TRAP_VEC_LO 16'h003e
`define IA_TRAP_VEC_HI 16'h003f
`define IA_LAT_HI_MIN 7
`define IA_LAT_LO_MIN 8
`define IA_WAIT_LAST 4'h3
`endif

// file: design/int_ack_prio.v
// interrupt acknowledge and priority logic for an 8-bit core, registers on classic wishbone
// Operation
// - eligible only when pending and unmasked
// - vector maskable only while accept enable set
// - high service blocks low priority requests
// - latency seven or eight clocks minimum
// - high priority wins over low priority
// - equal level resolved by fixed order
// - held requests stay pending until eligible
// - push status word then program counter
// - acknowledge clears enable, copies priority
// - load vector of acknowledged source
// - services end with return from interrupt
// - software trap always taken
// - trap pushes, clears enable, vector 003e
// - nesting only while enable set
// - nest equal or higher, refuse lower
// - refused request waits one main instruction
// - no nesting during non-maskable service
// - deferring instructions hold acknowledge one instruction
// - trap does not defer; non-maskable still taken
// - pending set ignores priority flag
// - pending cleared on acknowledge and reset
// - non-maskable unconditional and highest
// - status word resets to 02
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ns
`include "int_ack_map.vh"
module int_ack_prio
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // request sources, one pulse per event
    input wire [15:0] src_req_i,
    input wire nmi_req_i,
    // sequencer: instruction boundary and kind
    input wire instr_done_i,
    input wire instr_defer_i,
    input wire instr_trap_i,
    input wire instr_return_from_interrupt_instr_i,
    input wire instr_return_from_trap_instr_i,
    input wire instr_ei_i,
    input wire instr_di_i,
    input wire psw_wr_i,
    input wire [7:0] psw_wdat_i,
    input wire [15:0] pc_i,
    input wire stack_ready_i,
    input wire [7:0] psw_pop_i,
    // stacking and vectoring toward the sequencer
    output reg stack_wr_o,
    output reg [15:0] stack_dat_o,
    output reg stack_pc_o,
    output reg vec_load_o,
    output reg [15:0] vec_addr_o,
    output reg svc_busy_o,
    output reg [7:0] psw_o
);
    // ****************************************
    // state codes
    // ****************************************
    // one pad state, two push states and one vector state follow idle
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WAIT = 3'h1;
    localparam [2:0] S_PUSH_PSW = 3'h2;
    localparam [2:0] S_PUSH_PC = 3'h3;
    localparam [2:0] S_VECTOR = 3'h4;
    // kind of acknowledge being sequenced
    localparam [1:0] K_MASK = 2'h0;
    localparam [1:0] K_NMI = 2'h1;
    localparam [1:0] K_TRAP = 2'h2;
    // ****************************************
    // storage
    // ****************************************
    reg [15:0] pend_q; // request pending flags
    reg [15:0] mask_q; // request mask flags
    reg [15:0] prio_q; // priority select flags, 0 high
    reg [15:0] vbase_q; // base of vector table
    reg [7:0] psw_q; // status word with accept enable and serviced priority
    reg nmi_pend_q; // non-maskable request latched
    reg nmi_svc_q; // non-maskable service active
    // no separate hold flag: a deferring instruction blocks only its own boundary,
    // so the instruction after it (or after a return) is the first place to acknowledge
    reg [2:0] state_q; // acknowledge sequencer state
    reg [1:0] kind_q; // kind of acknowledge in progress
    reg [3:0] src_q; // winning source number
    reg [3:0] wait_q; // latency padding counter
    reg [7:0] psw_save_q; // status word captured at acknowledge
    reg [15:0] pc_save_q; // return address captured at acknowledge
    wire ie_w = psw_q[`IA_BIT_IE];
    wire isp_w = psw_q[`IA_BIT_ISP];
    // ****************************************
    // helper functions
    // ****************************************
    // lowest set bit index; bit 0 ranks highest by default
    // returns 16 (bit 4 set) when no bit is set, which the arbiter reads as no winner
    function [4:0] first_set;
        input [15:0] v;
        integer k;
        begin
            first_set = 5'h10;
            for (k = 15; k >= 0; k = k - 1)
            begin
                if (v[k])
                begin
                    first_set = k[4:0];
                end
            end
        end
    endfunction
    // byte merge under sel for 16-bit registers
    // the upper two byte lanes carry nothing for these registers
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] nw;
        input [3:0] sel;
        begin
            merge16 = old;
            if (sel[0])
            begin
                merge16[7:0] = nw[7:0];
            end
            if (sel[1])
            begin
                merge16[15:8] = nw[15:8];
            end
        end
    endfunction
    // ****************************************
    // arbitration
    // ****************************************
    // low priority sources drop out while a high priority service is active
    wire [15:0] elig_w = pend_q & ~mask_q;
    wire [15:0] elig_hi_w = elig_w & ~prio_q;
    wire [15:0] elig_lo_w = elig_w & prio_q & {16{isp_w}};
    wire [4:0] hi_idx_w = first_set(elig_hi_w);
    wire [4:0] lo_idx_w = first_set(elig_lo_w);
    wire [4:0] win_w = (elig_hi_w != 16'h0000) ? hi_idx_w : lo_idx_w;
    wire mask_ok_w = ie_w && !nmi_svc_q && !win_w[4];
    wire nmi_ok_w = nmi_pend_q && !nmi_svc_q;
    // acknowledge only where an instruction ends; a deferring one blocks its own end,
    // so the following instruction completes first; a trap never defers
    // a return is itself deferring, so one main instruction runs before a refused request
    wire boundary_w = instr_done_i && (!instr_defer_i || instr_trap_i);
    wire wb_req_w = cyc_i && stb_i && !ack_o;
    // ****************************************
    // wishbone slave and flag registers
    // ****************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pend_q <= `IA_RST_PEND;
            mask_q <= `IA_RST_MASK;
            prio_q <= `IA_RST_PRIO;
            vbase_q <= `IA_RST_VBASE;
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            // one wait state: ack follows the edge that takes the request, then drops
            ack_o <= wb_req_w;
            dat_o <= 32'h00000000;
            // software writes to the flag registers
            if (wb_req_w && we_i)
            begin
                case (adr_i)
                    `IA_OFF_PEND: ; // merged with the request events below
                    `IA_OFF_MASK: mask_q <= merge16(mask_q, dat_i, sel_i);
                    `IA_OFF_PRIO: prio_q <= merge16(prio_q, dat_i, sel_i);
                    `IA_OFF_VBASE: vbase_q <= merge16(vbase_q, dat_i, sel_i);
                    default: ;
                endcase
            end
            // read mux, unmapped reads zero
            if (wb_req_w && !we_i)
            begin
                case (adr_i)
                    `IA_OFF_PEND: dat_o <= {16'h0000, pend_q};
                    `IA_OFF_MASK: dat_o <= {16'h0000, mask_q};
                    `IA_OFF_PRIO: dat_o <= {16'h0000, prio_q};
                    `IA_OFF_STAT: dat_o <= {16'h0000, nmi_svc_q, nmi_pend_q, 1'b0, state_q, kind_q, psw_q};
                    `IA_OFF_VECT: dat_o <= {11'h000, win_w, vec_addr_o};
                    `IA_OFF_VBASE: dat_o <= {16'h0000, vbase_q};
                    default: dat_o <= 32'h00000000;
                endcase
            end
            // pending flags: software write, then the acknowledge clear, then new events on top
            pend_q <= pend_q_next(src_req_i);
        end
    end
    // combine write, clear and set so a new event wins over the clear;
    // the clear falls on the one edge that ends the status word push,
    // and an event of the same source on that edge still stays pending
    function [15:0] pend_q_next;
        input [15:0] set_v; // request pulses of this cycle
        reg [15:0] v;
        begin
            v = pend_q;
            if (wb_req_w && we_i && adr_i == `IA_OFF_PEND)
            begin
                v = merge16(pend_q, dat_i, sel_i);
            end
            // acknowledged source leaves the pending set
            if (state_q == S_PUSH_PSW && kind_q == K_MASK && stack_wr_o && stack_ready_i)
            begin
                v[src_q] = 1'b0;
            end
            pend_q_next = v | set_v;
        end
    endfunction
    // ****************************************
    // acknowledge sequencer
    // ****************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            psw_q <= `IA_RST_PSW;
            nmi_pend_q <= 1'b0;
            nmi_svc_q <= 1'b0;
            state_q <= S_IDLE;
            kind_q <= K_MASK;
            src_q <= 4'h0;
            wait_q <= 4'h0;
            psw_save_q <= 8'h00;
            pc_save_q <= 16'h0000;
            stack_wr_o <= 1'b0;
            stack_dat_o <= 16'h0000;
            stack_pc_o <= 1'b0;
            vec_load_o <= 1'b0;
            vec_addr_o <= 16'h0000;
            svc_busy_o <= 1'b0;
            psw_o <= `IA_RST_PSW;
        end
        else
        begin
            vec_load_o <= 1'b0;
            // status word mirror lags the register by one clock
            psw_o <= psw_q;
            // non-maskable pulses latch until their acknowledge is picked
            if (nmi_req_i)
            begin
                nmi_pend_q <= 1'b1;
            end
            // instruction kinds below may share one edge; the later assignment wins
            // instruction side effects on the status word
            if (instr_ei_i)
            begin
                psw_q[`IA_BIT_IE] <= 1'b1;
            end
            if (instr_di_i)
            begin
                psw_q[`IA_BIT_IE] <= 1'b0;
            end
            if (psw_wr_i)
            begin
                psw_q <= psw_wdat_i;
            end
            // both returns pop the status word; only the interrupt return ends a non-maskable service
            if (instr_return_from_interrupt_instr_i || instr_return_from_trap_instr_i)
            begin
                psw_q <= psw_pop_i;
                if (instr_return_from_interrupt_instr_i)
                begin
                    nmi_svc_q <= 1'b0;
                end
            end
            case (state_q)
                // pick the next acknowledge at an instruction boundary
                // a trap needs no boundary and no enable; non-maskable beats maskable
                S_IDLE:
                begin
                    if (instr_trap_i)
                    begin
                        kind_q <= K_TRAP;
                        state_q <= S_WAIT;
                        wait_q <= 4'h0;
                    end
                    else if (boundary_w && nmi_ok_w)
                    begin
                        kind_q <= K_NMI;
                        nmi_pend_q <= nmi_req_i; // taken now; a fresh pulse on this edge stays
                        state_q <= S_WAIT;
                        wait_q <= 4'h0;
                    end
                    else if (boundary_w && mask_ok_w)
                    begin
                        kind_q <= K_MASK;
                        src_q <= win_w[3:0];
                        state_q <= S_WAIT;
                        // a high priority source skips one pad cycle, so low waits one clock longer
                        wait_q <= prio_q[win_w[3:0]] ? 4'h0 : 4'h1;
                    end
                end
                // pad so service starts no earlier than the minimum latency
                S_WAIT:
                begin
                    svc_busy_o <= 1'b1;
                    wait_q <= wait_q + 4'h1;
                    // counting from 0 gives the low priority pad, from 1 the high one
                    if (wait_q == `IA_WAIT_LAST)
                    begin
                        state_q <= S_PUSH_PSW;
                        psw_save_q <= psw_q;
                        pc_save_q <= pc_i;
                    end
                end
                // status word goes onto the stack first
                S_PUSH_PSW:
                begin
                    stack_wr_o <= 1'b1;
                    stack_pc_o <= 1'b0;
                    stack_dat_o <= {8'h00, psw_save_q};
                    psw_q[`IA_BIT_IE] <= 1'b0;
                    if (kind_q == K_MASK)
                    begin
                        psw_q[`IA_BIT_ISP] <= prio_q[src_q];
                    end
                    else if (kind_q == K_NMI)
                    begin
                        psw_q[`IA_BIT_ISP] <= 1'b0;
                        // the non-maskable latch was cleared when this acknowledge was picked
                        nmi_svc_q <= 1'b1;
                    end
                    // a trap keeps the serviced priority
                    if (stack_wr_o && stack_ready_i)
                    begin
                        stack_wr_o <= 1'b0;
                        state_q <= S_PUSH_PC;
                    end
                end
                // then the program counter
                S_PUSH_PC:
                begin
                    stack_wr_o <= 1'b1;
                    stack_pc_o <= 1'b1;
                    stack_dat_o <= pc_save_q;
                    if (stack_wr_o && stack_ready_i)
                    begin
                        stack_wr_o <= 1'b0;
                        state_q <= S_VECTOR;
                    end
                end
                // load the vector and resume
                S_VECTOR:
                begin
                    vec_load_o <= 1'b1;
                    case (kind_q)
                        K_TRAP: vec_addr_o <= `IA_TRAP_VEC_LO;
                        K_NMI: vec_addr_o <= vbase_q - 16'h0002;
                        default: vec_addr_o <= vbase_q + {11'h000, src_q, 1'b0};
                    endcase
                    svc_busy_o <= 1'b0;
                    // the next acknowledge may be picked at the next boundary
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// file: verif/int_ack_prio_props.sv
// assertion checker for the interrupt acknowledge block
`timescale 1ns/1ns
`include "int_ack_map.vh"
module int_ack_prio_props
(
    // clock, reset and bus
    input wire clk_i,
    input wire rst_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // sequencer side
    input wire instr_trap_i,
    input wire stack_ready_i,
    input wire stack_wr_o,
    input wire [15:0] stack_dat_o,
    input wire stack_pc_o,
    input wire vec_load_o,
    input wire [15:0] vec_addr_o,
    input wire [7:0] psw_o
);
    reg trap_q; // a trap waits for its vector
    reg psw_q; // status word already pushed
    // ****************
    // helper flags, cleared by each vector load
    // ****************
    always @(posedge clk_i)
    begin
        if (rst_i || vec_load_o)
        begin
            trap_q <= 1'b0;
            psw_q <= 1'b0;
        end
        else
        begin
            trap_q <= trap_q | instr_trap_i;
            psw_q <= psw_q | (stack_wr_o & stack_ready_i & ~stack_pc_o);
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i > 8'h14 |-> dat_o == 32'h0) else $error("bad read");
    a_reset_status: assert property (disable iff (1'b0) rst_i |=> psw_o == `IA_RST_PSW) else $error("bad psw");
    a_status_first: assert property (stack_wr_o && stack_pc_o |-> psw_q) else $error("pc first");
    a_push_hold: assert property (stack_wr_o && !stack_ready_i |=> stack_wr_o && $stable(stack_dat_o))
        else $error("push dropped");
    a_vector_next: assert property (stack_wr_o && stack_pc_o && stack_ready_i |-> ##[1:8] vec_load_o)
        else $error("no vector");
    a_enable_clear: assert property (vec_load_o |-> !psw_o[`IA_BIT_IE]) else $error("ie kept");
    a_trap_vector: assert property (vec_load_o && trap_q |-> vec_addr_o == `IA_TRAP_VEC_LO)
        else $error("bad trap vector");
    c_trap: cover property (vec_load_o && trap_q);
    c_slow_push: cover property (stack_wr_o && !stack_ready_i ##1 stack_wr_o);
    c_write: cover property (ack_o && we_i);
endmodule
bind int_ack_prio int_ack_prio_props i_props (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .instr_trap_i(instr_trap_i), .stack_ready_i(stack_ready_i), .stack_wr_o(stack_wr_o),
    .stack_dat_o(stack_dat_o), .stack_pc_o(stack_pc_o), .vec_load_o(vec_load_o), .vec_addr_o(vec_addr_o),
    .psw_o(psw_o));

// file: verif/int_ack_prio_tb_top.sv
// self-checking bench for the interrupt acknowledge block
`timescale 1ns/1ns
`include "int_ack_map.vh"
module int_ack_prio_tb_top;
    // driven inputs; kind is done, defer, trap, return_from_interrupt_instr, return_from_trap_instr, ei, di
    reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, nmi_req_i = 1'b0, psw_wr_i = 1'b0;
    reg [7:0] adr_i = 8'h00, psw_wdat_i = 8'h00, psw_pop_i = 8'h82;
    reg [31:0] dat_i = 32'h0, rd;
    reg [15:0] src_req_i = 16'h0, pc_i = 16'h1234;
    reg [6:0] kind = 7'h0;
    reg [3:0] wait_n = 4'h2; // stack answer delay
    // observed outputs
    wire [31:0] dat_o;
    wire [15:0] stack_dat_o, vec_addr_o, psw_seen, pc_seen;
    wire [7:0] psw_o;
    wire ack_o, stack_ready_i, stack_wr_o, stack_pc_o, vec_load_o, svc_busy_o, order_ok;
    integer n_errors = 0, tests_run = 0, cycles = 0;
    localparam NONE = 16'hffff, K_PL = 6'h00, K_TRAP = 6'h10, K_RETURN_FROM_INTERRUPT_INSTR = 6'h28, K_RETURN_FROM_TRAP_INSTR = 6'h24, K_EI = 6'h22, K_DI = 6'h21;
    int_ack_prio i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .src_req_i(src_req_i), .nmi_req_i(nmi_req_i),
        .instr_done_i(kind[6]), .instr_defer_i(kind[5]), .instr_trap_i(kind[4]), .instr_return_from_interrupt_instr_i(kind[3]),
        .instr_return_from_trap_instr_i(kind[2]), .instr_ei_i(kind[1]), .instr_di_i(kind[0]), .psw_wr_i(psw_wr_i),
        .psw_wdat_i(psw_wdat_i), .pc_i(pc_i), .stack_ready_i(stack_ready_i), .psw_pop_i(psw_pop_i),
        .stack_wr_o(stack_wr_o), .stack_dat_o(stack_dat_o), .stack_pc_o(stack_pc_o), .vec_load_o(vec_load_o),
        .vec_addr_o(vec_addr_o), .svc_busy_o(svc_busy_o), .psw_o(psw_o));
    stack_model i_stack (.clk_i(clk_i), .rst_i(rst_i), .stack_wr_o(stack_wr_o), .stack_dat_o(stack_dat_o),
        .stack_pc_o(stack_pc_o), .wait_i(wait_n), .stack_ready_i(stack_ready_i), .psw_seen_o(psw_seen),
        .pc_seen_o(pc_seen), .order_ok_o(order_ok));
    always #10 clk_i = ~clk_i;
    // ****************
    // shared tasks
    // ****************
    task results;
        begin
            $display("errors=%0d checks=%0d", n_errors, tests_run);
            if (n_errors == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // classic bus cycle, held until ack is sampled
    task wb(input w, input [7:0] a, input [31:0] wd);
        begin
            @(posedge clk_i);
            {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, wd};
            @(posedge clk_i);
            while (ack_o !== 1'b1)
                @(posedge clk_i);
            rd = dat_o;
            {cyc_i, stb_i} <= 2'b00;
        end
    endtask
    task req(input [15:0] s, input n);
        begin
            @(posedge clk_i);
            {src_req_i, nmi_req_i} <= {s, n};
            @(posedge clk_i);
            {src_req_i, nmi_req_i} <= 17'h0;
        end
    endtask
    // one instruction completes; expect a vector (or none) and a least latency,
    // counted from a request driven three edges before the boundary to the first push
    task instr(input [5:0] k, input [15:0] exp, input integer lo);
        integer n, n_push;
        reg [15:0] got;
        begin
            @(posedge clk_i);
            while (svc_busy_o !== 1'b0)
                @(posedge clk_i);
            kind <= {1'b1, k};
            @(posedge clk_i);
            kind <= 7'h00;
            got = NONE;
            n_push = 0;
            for (n = 1; n < 40 && got === NONE; n = n + 1)
            begin
                @(posedge clk_i);
                if (stack_wr_o === 1'b1 && n_push == 0)
                    n_push = n;
                if (vec_load_o === 1'b1)
                    got = vec_addr_o;
            end
            check(got, exp);
            if (got !== NONE)
                check(n_push + 2 >= lo, 1'b1);
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task t_reset;
        begin
            wb(1'b0, `IA_OFF_PEND, 32'h0);
            check(rd, `IA_RST_PEND);
            wb(1'b0, `IA_OFF_STAT, 32'h0);
            check(rd[7:0], `IA_RST_PSW);
            wb(1'b1, 8'h20, 32'hffffffff);
            wb(1'b0, 8'h20, 32'h0);
            check(rd, 32'h0);
        end
    endtask
    task t_mask;
        begin
            req(16'h0008, 1'b0);
            instr(K_EI, NONE, 0);
            instr(K_PL, NONE, 0);
            wb(1'b0, `IA_OFF_PEND, 32'h0);
            check(rd, 32'h8);
            wb(1'b1, `IA_OFF_MASK, 32'hfff7);
            instr(K_PL, 16'h000a, `IA_LAT_LO_MIN);
            check({order_ok, psw_seen[7:0], pc_seen}, {1'b1, 8'h82, 16'h1234});
            check(psw_o, 8'h02);
            wb(1'b0, `IA_OFF_PEND, 32'h0);
            check(rd, 32'h0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
        end
    endtask
    task t_prio;
        begin
            wait_n <= 4'h0;
            wb(1'b1, `IA_OFF_PRIO, 32'hffdf);
            wb(1'b1, `IA_OFF_MASK, 32'hfdcb);
            req(16'h0024, 1'b0);
            instr(K_PL, 16'h000e, `IA_LAT_HI_MIN);
            check(psw_o, 8'h00);
            instr(K_EI, NONE, 0);
            instr(K_PL, NONE, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            instr(K_PL, 16'h0008, 0);
            instr(K_EI, NONE, 0);
            req(16'h0004, 1'b0);
            instr(K_PL, 16'h0008, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            req(16'h0210, 1'b0);
            instr(K_PL, 16'h000c, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            instr(K_PL, 16'h0016, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            instr(K_DI, NONE, 0);
            req(16'h0010, 1'b0);
            instr(K_PL, NONE, 0);
            instr(K_EI, NONE, 0);
            instr(K_PL, 16'h000c, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
        end
    endtask
    task t_trap;
        begin
            wait_n <= 4'h3;
            @(posedge clk_i);
            {psw_wr_i, psw_wdat_i} <= {1'b1, 8'h82};
            @(posedge clk_i);
            psw_wr_i <= 1'b0;
            wb(1'b1, `IA_OFF_MASK, 32'hffff);
            instr(K_TRAP, `IA_TRAP_VEC_LO, 0);
            check(psw_o, 8'h02);
            req(16'h0000, 1'b1);
            instr(K_PL, `IA_RST_VBASE - 16'h2, 0);
            wb(1'b1, `IA_OFF_MASK, 32'hffef);
            req(16'h0010, 1'b0);
            instr(K_EI, NONE, 0);
            instr(K_PL, NONE, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            instr(K_PL, 16'h000c, 0);
            instr(K_RETURN_FROM_INTERRUPT_INSTR, NONE, 0);
            instr(K_RETURN_FROM_TRAP_INSTR, NONE, 0);
        end
    endtask
    // timeout, then the sequence itself
    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            results;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_mask;
        t_prio;
        t_trap;
        results;
    end
endmodule

// file: verif/stack_model.sv
// stack side of the sequencer: answers pushes after a set delay and keeps the last ones
`timescale 1ns/1ns
module stack_model
(
    // clock, reset, push request, delay
    input wire clk_i,
    input wire rst_i,
    input wire stack_wr_o,
    input wire [15:0] stack_dat_o,
    input wire stack_pc_o,
    input wire [3:0] wait_i,
    // answer and log
    output reg stack_ready_i,
    output reg [15:0] psw_seen_o,
    output reg [15:0] pc_seen_o,
    output reg order_ok_o
);
    reg [3:0] cnt_q; // cycles this push has waited
    reg last_psw_q; // previous push held the status word
    // ****************
    // one-cycle answer after the delay, then log the word
    // ****************
    always @(posedge clk_i)
    begin
        cnt_q <= (stack_wr_o && !stack_ready_i) ? cnt_q + 4'h1 : 4'h0;
        stack_ready_i <= stack_wr_o && !stack_ready_i && cnt_q >= wait_i && !rst_i;
        if (stack_wr_o && stack_ready_i)
        begin
            if (stack_pc_o)
            begin
                pc_seen_o <= stack_dat_o;
                order_ok_o <= last_psw_q;
            end
            else
                psw_seen_o <= stack_dat_o;
            last_psw_q <= !stack_pc_o;
        end
    end
endmodule
